// ### verilog/awea_pkg.sv
// Package: register map, field layout and types of the wake event aggregator
package awea_pkg;

  // ----------------------------------------------------------------
  // Register indices as printed (not all multiples of four)
  // ----------------------------------------------------------------
  localparam logic [4:0] AWEA_IDX_GSTS = 5'h00; // Global power event status
  localparam logic [4:0] AWEA_IDX_GEN = 5'h04; // Global power event enable
  localparam logic [4:0] AWEA_IDX_STS0 = 5'h08; // Bank 0 pin status
  localparam logic [4:0] AWEA_IDX_STS1 = 5'h09; // Bank 1 pin status
  localparam logic [4:0] AWEA_IDX_STS2 = 5'h0a; // Input event status
  localparam logic [4:0] AWEA_IDX_STS3 = 5'h0b; // Interrupt wake status
  localparam logic [4:0] AWEA_IDX_EN0 = 5'h0c; // Bank 0 pin enable
  localparam logic [4:0] AWEA_IDX_EN1 = 5'h0d; // Bank 1 pin enable
  localparam logic [4:0] AWEA_IDX_EN2 = 5'h0e; // Input event enable
  localparam logic [4:0] AWEA_IDX_EN3 = 5'h0f; // Interrupt wake enable
  localparam logic [4:0] AWEA_IDX_IRQ_STS = 5'h10; // Block interrupt status
  localparam logic [4:0] AWEA_IDX_IRQ_MSK = 5'h11; // Block interrupt mask

  // ----------------------------------------------------------------
  // Implemented bits per child register, others reserved
  // ----------------------------------------------------------------
  localparam logic [7:0] AWEA_MASK_B0 = 8'h_ff; // Bank 0 pins 7..0
  localparam logic [7:0] AWEA_MASK_B1 = 8'h_0f; // Bank 1 pins 3..0
  localparam logic [7:0] AWEA_MASK_INP = 8'h_fe; // Keys, mouse, rings
  localparam logic [7:0] AWEA_MASK_IRQ = 8'h_1c; // Module, mouse, kbd IRQ
  localparam logic [7:0] AWEA_RST_BYTE = 8'h_00; // Reset of every register

  // Field positions in the input event byte
  localparam int AWEA_BIT_KEY3 = 7;
  localparam int AWEA_BIT_KEY2 = 6;
  localparam int AWEA_BIT_PRIM = 5;
  localparam int AWEA_BIT_MOUSE = 4;
  localparam int AWEA_BIT_ANYK = 3;
  localparam int AWEA_BIT_RING1 = 2;
  localparam int AWEA_BIT_RING2 = 1;
  // Field positions in the interrupt wake byte
  localparam int AWEA_BIT_MODIRQ = 4;
  localparam int AWEA_BIT_MSIRQ = 3;
  localparam int AWEA_BIT_KBDIRQ = 2;

  // Keyboard wake detector modes
  typedef enum logic [1:0] {
    AWEA_KMODE_SEQ = 2'b00, // Special sequence or password
    AWEA_KMODE_FAST = 2'b01, // Fast any-key
    AWEA_KMODE_PMK = 2'b10, // Power management keys
    AWEA_KMODE_RSV = 2'b11 // Unused
  } awea_kmode_t;

  // Bus slave data phase state
  typedef enum logic [1:0] {
    AWEA_ST_IDLE = 2'b00,
    AWEA_ST_WRITE = 2'b01,
    AWEA_ST_READ = 2'b10
  } awea_state_t;

  // Four child bytes travel together
  typedef struct packed {
    logic [7:0] irq; // Interrupt wake byte
    logic [7:0] inp; // Input event byte
    logic [7:0] b1; // Bank 1 pins
    logic [7:0] b0; // Bank 0 pins
  } awea_child_t;

endpackage : awea_pkg

// ### verilog/awea_top.sv
// Wake event aggregator: sticky child events, enables, global event, SCI
// Behaviour
// - Child status sticky, cleared by writing one
// - Bank1 pins 3..0 latch into 09h
// - Keys 3,2 latch in PM keys mode
// - Bit5 latches primary keyboard event in sequence or PM keys mode
// - Bit4 latches identified mouse event
// - Bit3 latches any key, fast mode only
// - Ring falling edges latch bits 2,1
// - Module IRQ latches if active, wake-enabled
// - Mouse controller IRQ latches if kbc active, wake-enabled
// - Keyboard controller IRQ latches if kbc active, wake-enabled
// - Enables plain storage, gate global event
// - Enable 0Dh mirrors bank1 layout
// - Enable 0Eh mirrors input layout
// - Enable 0Fh mirrors interrupt layout
// - Global status set by enabled child
// - Global enable gates the SCI output
// - Bank0 pins 7..0 latch into 08h
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
module awea_top
  import awea_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Event sources, all asynchronous to hclk
  input wire logic [7:0] pin_b0_active,
  input wire logic [3:0] pin_b1_active,
  input wire logic [1:0] kbd_mode,
  input wire logic pm_key3_press,
  input wire logic pm_key2_press,
  input wire logic primary_key_event,
  input wire logic mouse_event,
  input wire logic any_key_press,
  input wire logic ring_port1_n,
  input wire logic ring_port2_n,
  input wire logic module_irq,
  input wire logic module_active,
  input wire logic module_wake_en,
  input wire logic kbc_active,
  input wire logic mouse_irq,
  input wire logic mouse_wake_en,
  input wire logic keyboard_irq,
  input wire logic keyboard_wake_en,
  // Outputs
  output logic power_event_output,
  output logic irq
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 29; // Asynchronous source bits
  logic [NSYNC-1:0] raw_in; // Raw source vector
  logic [NSYNC-1:0] sync1_q; // First stage, read only by stage two
  logic [NSYNC-1:0] sync2_q; // Safe stage
  logic [1:0] ring_prev_q; // Ring level one cycle back

  assign raw_in = {pin_b0_active, pin_b1_active, kbd_mode, pm_key3_press,
                   pm_key2_press, primary_key_event, mouse_event,
                   any_key_press, ring_port1_n, ring_port2_n, module_irq,
                   module_active, module_wake_en, kbc_active, mouse_irq,
                   mouse_wake_en, keyboard_irq, keyboard_wake_en};

  // Two flops per bit, each bit one loop entry
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= raw_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  // Named views of the synchronised sources
  logic [7:0] s_b0;
  logic [3:0] s_b1;
  awea_kmode_t s_mode;
  logic s_k3, s_k2, s_prim, s_mouse, s_anyk, s_ri1, s_ri2;
  logic s_mirq, s_mact, s_mwk, s_kact, s_msirq, s_mswk, s_kbirq, s_kbwk;
  assign {s_b0, s_b1} = sync2_q[28:17];
  assign s_mode = awea_kmode_t'(sync2_q[16:15]);
  assign {s_k3, s_k2, s_prim, s_mouse, s_anyk} = sync2_q[14:10];
  assign {s_ri1, s_ri2, s_mirq, s_mact, s_mwk} = sync2_q[9:5];
  assign {s_kact, s_msirq, s_mswk, s_kbirq, s_kbwk} = sync2_q[4:0];

  // ----------------------------------------------------------------
  // Hardware set terms per child bit
  // ----------------------------------------------------------------
  awea_child_t hw_set; // Raw set requests this cycle
  always_comb begin
    hw_set = '0;
    hw_set.b0 = s_b0;
    hw_set.b1 = {4'h0, s_b1};
    hw_set.inp[AWEA_BIT_KEY3] = s_k3 && (s_mode == AWEA_KMODE_PMK);
    hw_set.inp[AWEA_BIT_KEY2] = s_k2 && (s_mode == AWEA_KMODE_PMK);
    // Primary event meaning depends on mode; detector qualifies it
    hw_set.inp[AWEA_BIT_PRIM] = s_prim && (s_mode != AWEA_KMODE_FAST) &&
                                (s_mode != AWEA_KMODE_RSV);
    hw_set.inp[AWEA_BIT_MOUSE] = s_mouse;
    hw_set.inp[AWEA_BIT_ANYK] = s_anyk && (s_mode == AWEA_KMODE_FAST);
    // Falling edge of ring indicate, after synchronising
    // History resets low: the idle-high line leaving reset is no event
    hw_set.inp[AWEA_BIT_RING1] = ring_prev_q[1] && !s_ri1;
    hw_set.inp[AWEA_BIT_RING2] = ring_prev_q[0] && !s_ri2;
    hw_set.irq[AWEA_BIT_MODIRQ] = s_mirq && s_mact && s_mwk;
    hw_set.irq[AWEA_BIT_MSIRQ] = s_msirq && s_kact && s_mswk;
    hw_set.irq[AWEA_BIT_KBDIRQ] = s_kbirq && s_kact && s_kbwk;
  end
  // The keyboard controller group rides the five lowest sync bits,
  // in the same order as the port list.

  // ----------------------------------------------------------------
  // AHB-Lite slave data phase capture
  // ----------------------------------------------------------------
  awea_state_t st_q, st_d; // Pending data phase kind
  logic [4:0] idx_q, idx_d; // Register index of pending phase
  logic [31:0] rdata_q, rdata_d; // Read data output flop
  logic take; // Valid address phase this cycle

  assign take = hsel && hready && htrans[1];

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  awea_child_t sts_q, sts_d; // Child status
  awea_child_t en_q, en_d; // Child enables
  logic gsts_q, gsts_d; // Global power event status
  logic gen_q, gen_d; // Global power event enable
  logic [1:0] ist_q, ist_d; // Block irq status: global set, ring
  logic [1:0] imsk_q, imsk_d; // Block irq mask
  logic sci_q, sci_d; // Output flop for SCI
  logic irq_q, irq_d; // Output flop for block irq
  logic [1:0] ring_prev_d;
  logic [7:0] wb; // Low byte of write data
  logic wr_hit; // Write data phase this cycle
  logic [31:0] clr; // Write-one-clear mask to child status
  logic any_enabled; // Some enabled child active
  awea_child_t live; // Status after this cycle's sets
  awea_child_t rmask; // Implemented bit masks

  assign rmask = {AWEA_MASK_IRQ, AWEA_MASK_INP, AWEA_MASK_B1, AWEA_MASK_B0};
  assign wb = hwdata[7:0];
  assign wr_hit = (st_q == AWEA_ST_WRITE);

  // Next state for bus, status and enables
  always_comb begin
    st_d = AWEA_ST_IDLE;
    idx_d = idx_q;
    rdata_d = rdata_q;
    en_d = en_q;
    gen_d = gen_q;
    imsk_d = imsk_q;
    clr = '0;
    ring_prev_d = {s_ri1, s_ri2};
    // Write data phase: decode the index captured earlier
    if (wr_hit) begin
      case (idx_q)
        AWEA_IDX_STS0: clr[7:0] = wb;
        AWEA_IDX_STS1: clr[15:8] = wb;
        AWEA_IDX_STS2: clr[23:16] = wb;
        AWEA_IDX_STS3: clr[31:24] = wb;
        AWEA_IDX_EN0: en_d.b0 = wb & AWEA_MASK_B0;
        AWEA_IDX_EN1: en_d.b1 = wb & AWEA_MASK_B1;
        AWEA_IDX_EN2: en_d.inp = wb & AWEA_MASK_INP;
        AWEA_IDX_EN3: en_d.irq = wb & AWEA_MASK_IRQ;
        AWEA_IDX_GEN: gen_d = wb[0];
        AWEA_IDX_IRQ_MSK: imsk_d = wb[1:0];
        default: ;
      endcase
    end
    // Sets always win over a write-one clear in the same cycle
    live = awea_child_t'(((sts_q & ~clr) | hw_set) & rmask);
    sts_d = live;
    any_enabled = |(live & en_d);
    // Global status: set by enabled child; cleared only when none remain
    gsts_d = gsts_q | any_enabled;
    if (wr_hit && idx_q == AWEA_IDX_GSTS && wb[0] && !any_enabled) begin
      gsts_d = 1'b0;
    end
    if (any_enabled) begin
      gsts_d = 1'b1;
    end
    // Block irq status: rising global event and ring events
    ist_d = ist_q;
    if (st_q == AWEA_ST_READ && idx_q == AWEA_IDX_IRQ_STS) begin
      ist_d = 2'b00; // Read clears
    end
    if (gsts_d && !gsts_q) begin
      ist_d[0] = 1'b1;
    end
    if (|(hw_set.inp[2:1])) begin
      ist_d[1] = 1'b1;
    end
    sci_d = gsts_d && gen_d;
    irq_d = |(ist_d & imsk_d);
    // Address phase capture
    if (take) begin
      idx_d = haddr[6:2];
      st_d = hwrite ? AWEA_ST_WRITE : AWEA_ST_READ;
      rdata_d = 32'h0000_0000;
      if (!hwrite) begin
        case (haddr[6:2])
          AWEA_IDX_GSTS: rdata_d[0] = gsts_q;
          AWEA_IDX_GEN: rdata_d[0] = gen_q;
          AWEA_IDX_STS0: rdata_d[7:0] = sts_q.b0;
          AWEA_IDX_STS1: rdata_d[7:0] = sts_q.b1;
          AWEA_IDX_STS2: rdata_d[7:0] = sts_q.inp;
          AWEA_IDX_STS3: rdata_d[7:0] = sts_q.irq;
          AWEA_IDX_EN0: rdata_d[7:0] = en_q.b0;
          AWEA_IDX_EN1: rdata_d[7:0] = en_q.b1;
          AWEA_IDX_EN2: rdata_d[7:0] = en_q.inp;
          AWEA_IDX_EN3: rdata_d[7:0] = en_q.irq;
          AWEA_IDX_IRQ_STS: rdata_d[1:0] = ist_q;
          AWEA_IDX_IRQ_MSK: rdata_d[1:0] = imsk_q;
          default: rdata_d = 32'h0000_0000; // Unmapped reads zero
        endcase
      end
    end
  end

  // Register all state but the synchronisers; asynchronous reset to constants
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= AWEA_ST_IDLE;
      idx_q <= 5'h00;
      rdata_q <= 32'h0000_0000;
      sts_q <= '0;
      en_q <= '0;
      gsts_q <= 1'b0;
      gen_q <= 1'b0;
      ist_q <= 2'b00;
      imsk_q <= 2'b00;
      sci_q <= 1'b0;
      irq_q <= 1'b0;
      ring_prev_q <= 2'b00;
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
      rdata_q <= rdata_d;
      sts_q <= sts_d;
      en_q <= en_d;
      gsts_q <= gsts_d;
      gen_q <= gen_d;
      ist_q <= ist_d;
      imsk_q <= imsk_d;
      sci_q <= sci_d;
      irq_q <= irq_d;
      ring_prev_q <= ring_prev_d;
    end
  end

  // Zero wait state, always OKAY
  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign power_event_output = sci_q;
  assign irq = irq_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // All checks sample on hclk and stay quiet while reset is low
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Sticky status: set by hardware, taken down only by a one
  a_sticky_hold: assert property (
    $fell(sts_q.b0[0]) |->
    $past(wr_hit && idx_q == AWEA_IDX_STS0 && wb[0])
  ) else $error("status bit fell without clear");
  a_zero_write: assert property (
    (wr_hit && idx_q == AWEA_IDX_STS1 && !wb[3] && sts_q.b1[3]) |=>
    sts_q.b1[3]
  ) else $error("zero write cleared a status bit");
  a_one_clear: assert property (
    (wr_hit && idx_q == AWEA_IDX_STS2 && wb[AWEA_BIT_MOUSE] &&
    !hw_set.inp[AWEA_BIT_MOUSE]) |=> !sts_q.inp[AWEA_BIT_MOUSE]
  ) else $error("one write left a status bit set");
  a_set_wins: assert property (
    hw_set.b1[0] |=> sts_q.b1[0]
  ) else $error("set lost");

  // Pin sources latch on an active level
  a_b1_latch: assert property (
    s_b1[3] |=> sts_q.b1[3]
  ) else $error("bank1 pin not latched");
  a_b0_latch: assert property (
    s_b0[7] |=> sts_q.b0[7]
  ) else $error("bank0 pin not latched");

  // Input event sources; keyboard ones qualified by the detector mode
  a_key3_mode: assert property (
    $rose(sts_q.inp[AWEA_BIT_KEY3]) |-> $past(s_mode == AWEA_KMODE_PMK)
  ) else $error("key3 set outside pm mode");
  a_key2_mode: assert property (
    $rose(sts_q.inp[AWEA_BIT_KEY2]) |-> $past(s_mode == AWEA_KMODE_PMK)
  ) else $error("key2 set outside pm mode");
  a_prim_mode: assert property (
    $rose(sts_q.inp[AWEA_BIT_PRIM]) |->
    $past(s_mode == AWEA_KMODE_SEQ || s_mode == AWEA_KMODE_PMK)
  ) else $error("primary key event set in wrong mode");
  a_mouse_latch: assert property (
    s_mouse |=> sts_q.inp[AWEA_BIT_MOUSE]
  ) else $error("mouse event not latched");
  a_anyk_mode: assert property (
    $rose(sts_q.inp[AWEA_BIT_ANYK]) |-> $past(s_mode == AWEA_KMODE_FAST)
  ) else $error("any key set outside fast mode");
  a_ring_edge: assert property (
    (ring_prev_q[1] && !s_ri1) |=> sts_q.inp[AWEA_BIT_RING1]
  ) else $error("ring edge missed");
  a_ring2_edge: assert property (
    (ring_prev_q[0] && !s_ri2) |=> sts_q.inp[AWEA_BIT_RING2]
  ) else $error("ring2 edge missed");

  // Interrupt sources need their module active and wake enabled
  a_modirq_gate: assert property (
    $rose(sts_q.irq[AWEA_BIT_MODIRQ]) |-> $past(s_mact && s_mwk)
  ) else $error("module irq set while gated");
  a_msirq_gate: assert property (
    $rose(sts_q.irq[AWEA_BIT_MSIRQ]) |-> $past(s_kact && s_mswk)
  ) else $error("mouse irq set while gated");
  a_kbdirq_gate: assert property (
    $rose(sts_q.irq[AWEA_BIT_KBDIRQ]) |-> $past(s_kact && s_kbwk)
  ) else $error("keyboard irq set while gated");

  // Reserved bits, global status and the SCI output
  a_reserved_zero: assert property (
    ((sts_q & ~rmask) == '0) && ((en_q & ~rmask) == '0)
  ) else $error("reserved bit set");
  a_global_set: assert property (
    |(sts_q & en_q) |=> gsts_q
  ) else $error("global not set");
  a_global_clear: assert property (
    $fell(gsts_q) |-> $past(wr_hit && idx_q == AWEA_IDX_GSTS && wb[0] &&
    ((sts_q & en_q) == '0))
  ) else $error("global status cleared while a child was enabled");
  a_sci_gate: assert property (
    power_event_output == (gsts_q && gen_q)
  ) else $error("sci does not follow global status and enable");

  // Enable storage keeps only implemented bits
  a_enable_store: assert property (
    (wr_hit && idx_q == AWEA_IDX_EN2) |=> en_q.inp == $past(wb & 8'h_fe)
  ) else $error("enable not stored");
  a_en1_store: assert property (
    (wr_hit && idx_q == AWEA_IDX_EN1) |=>
    en_q.b1 == $past(wb & AWEA_MASK_B1)
  ) else $error("bank1 enable not stored");
  a_en3_store: assert property (
    (wr_hit && idx_q == AWEA_IDX_EN3) |=>
    en_q.irq == $past(wb & AWEA_MASK_IRQ)
  ) else $error("interrupt enable not stored");
  a_gen_store: assert property (
    (wr_hit && idx_q == AWEA_IDX_GEN) |=> gen_q == $past(wb[0])
  ) else $error("global enable not stored");

endmodule : awea_top

// ### tb/awea_sci_sink.sv
// Partner model: far-side power event receiver counting SCI assertions
`timescale 1ns/10ps
module awea_sci_sink
  import awea_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sci_level,
  output logic [7:0] rise_count
);
  // ----------------------------------------------------------------
  // Edge counter
  // ----------------------------------------------------------------
  logic prev_q; // Level seen at the previous edge

  // A level interrupt may stand for long; only new assertions count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= 1'b0;
      rise_count <= 8'h00;
    end else begin
      prev_q <= sci_level;
      if (sci_level && !prev_q) begin
        rise_count <= rise_count + 8'h01;
      end
    end
  end
endmodule : awea_sci_sink

// ### tb/testbench.sv
// Testbench: registers, wake events and SCI of the wake event aggregator
`timescale 1ns/10ps
module testbench;
  import awea_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, sci, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, kbd_mode;
  logic [2:0] hsize;
  logic [7:0] pin_b0, sci_rises;
  logic [3:0] pin_b1;
  logic key3, key2, prim, mouse, anyk, ring1_n, ring2_n;
  logic mod_irq, mod_act, mod_wk, kbc_act, ms_irq, ms_wk, kb_irq, kb_wk;
  logic [4:0] all_idx [12]; // Every mapped register
  logic [4:0] en_idx [4]; // Child enable registers
  logic [7:0] en_mask [4]; // Writable bits of each enable
  int errors, comparisons;

  awea_top u_awea_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pin_b0_active(pin_b0),
    .pin_b1_active(pin_b1), .kbd_mode(kbd_mode), .pm_key3_press(key3),
    .pm_key2_press(key2), .primary_key_event(prim), .mouse_event(mouse),
    .any_key_press(anyk), .ring_port1_n(ring1_n), .ring_port2_n(ring2_n),
    .module_irq(mod_irq), .module_active(mod_act),
    .module_wake_en(mod_wk), .kbc_active(kbc_act), .mouse_irq(ms_irq),
    .mouse_wake_en(ms_wk), .keyboard_irq(kb_irq),
    .keyboard_wake_en(kb_wk), .power_event_output(sci), .irq(irq));

  // Far side sees only the SCI level
  awea_sci_sink u_awea_sci_sink (.hclk(hclk), .hresetn(hresetn),
    .sci_level(sci), .rise_count(sci_rises));

  // 50 MHz clock
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // Reporting and compare tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("Comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk32(string name, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk32

  task automatic chk1(string name, logic exp, logic got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask : chk1

  // ----------------------------------------------------------------
  // AHB-Lite master
  // ----------------------------------------------------------------
  // Bounded wait for hready high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        errors++;
        give_verdict();
      end
      @(posedge hclk);
    end
  endtask : wait_rdy

  // One single word transfer; byte address is four times the index
  task automatic bus(logic wr, logic [4:0] idx, logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {25'h000_0000, idx, 2'b00};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk1("hresp", 1'b0, hresp);
  endtask : bus

  task automatic wr(logic [4:0] idx, logic [7:0] d);
    bus(1'b1, idx, {24'h00_0000, d});
  endtask : wr

  task automatic rd_chk(string name, logic [4:0] idx, logic [7:0] exp);
    bus(1'b0, idx, 32'h0000_0000);
    chk32(name, {24'h00_0000, exp}, rd);
  endtask : rd_chk

  // ----------------------------------------------------------------
  // Event helpers
  // ----------------------------------------------------------------
  // Sources back to idle; ring lines idle high
  task automatic idle();
    {pin_b0, pin_b1, key3, key2, prim, mouse, anyk} <= '0;
    {mod_irq, mod_act, mod_wk, kbc_act, ms_irq, ms_wk, kb_irq} <= '0;
    kb_wk <= 1'b0;
    ring1_n <= 1'b1;
    ring2_n <= 1'b1;
  endtask : idle

  // Two sync edges plus the set edge, with margin
  task automatic settle();
    repeat (6) @(posedge hclk);
  endtask : settle

  // Pulse ends, then sticky status must hold, ignore zero, clear on one
  task automatic ev(string name, logic [4:0] idx, logic [7:0] exp);
    settle();
    idle();
    settle();
    rd_chk(name, idx, exp);
    wr(idx, 8'h00);
    rd_chk(name, idx, exp);
    wr(idx, 8'hff);
    rd_chk(name, idx, 8'h00);
  endtask : ev

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    all_idx = '{AWEA_IDX_GSTS, AWEA_IDX_GEN, AWEA_IDX_STS0, AWEA_IDX_STS1,
      AWEA_IDX_STS2, AWEA_IDX_STS3, AWEA_IDX_EN0, AWEA_IDX_EN1,
      AWEA_IDX_EN2, AWEA_IDX_EN3, AWEA_IDX_IRQ_STS, AWEA_IDX_IRQ_MSK};
    en_idx = '{AWEA_IDX_EN0, AWEA_IDX_EN1, AWEA_IDX_EN2, AWEA_IDX_EN3};
    en_mask = '{8'hff, 8'h0f, 8'hfe, 8'h1c};
    errors = 0;
    comparisons = 0;
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata, kbd_mode} = '0;
    hsize = 3'b010;
    {pin_b0, pin_b1, key3, key2, prim, mouse, anyk} = '0;
    {mod_irq, mod_act, mod_wk, kbc_act, ms_irq, ms_wk, kb_irq, kb_wk} = '0;
    {ring1_n, ring2_n} = 2'b11;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Every register clears at reset
    for (int i = 0; i < 12; i++) rd_chk("reset", all_idx[i], 8'h00);
    // Enables hold only their implemented bits
    for (int i = 0; i < 4; i++) begin
      wr(en_idx[i], 8'hff);
      rd_chk("enable", en_idx[i], en_mask[i]);
      wr(en_idx[i], 8'h00);
      rd_chk("enable", en_idx[i], 8'h00);
    end
    wr(5'h1f, 8'hff);
    rd_chk("unmapped", 5'h1f, 8'h00);
    // Child events, one source group at a time
    pin_b0 <= 8'ha5;
    ev("bank0", AWEA_IDX_STS0, 8'ha5);
    pin_b1 <= 4'h9;
    ev("bank1", AWEA_IDX_STS1, 8'h09);
    kbd_mode <= 2'b10;
    {key3, key2, prim, anyk} <= 4'hf;
    ev("pm keys", AWEA_IDX_STS2, 8'he0);
    kbd_mode <= 2'b01;
    {key3, key2, prim, anyk} <= 4'hf;
    ev("fast", AWEA_IDX_STS2, 8'h08);
    kbd_mode <= 2'b00;
    {key3, key2, prim, mouse, anyk} <= 5'h1f;
    ev("sequence", AWEA_IDX_STS2, 8'h30);
    // Unused detector mode: only the mouse event may latch
    kbd_mode <= 2'b11;
    {key3, key2, prim, mouse, anyk} <= 5'h1f;
    ev("unused mode", AWEA_IDX_STS2, 8'h10);
    ring1_n <= 1'b0;
    ev("ring1", AWEA_IDX_STS2, 8'h04);
    ring2_n <= 1'b0;
    ev("ring2", AWEA_IDX_STS2, 8'h02);
    {mod_irq, mod_act} <= 2'b11;
    ev("module off", AWEA_IDX_STS3, 8'h00);
    {mod_irq, mod_act, mod_wk} <= 3'b111;
    ev("module", AWEA_IDX_STS3, 8'h10);
    {ms_irq, ms_wk, kb_irq, kb_wk} <= 4'hf;
    ev("kbc off", AWEA_IDX_STS3, 8'h00);
    {kbc_act, ms_irq, ms_wk, kb_irq, kb_wk} <= 5'h1f;
    ev("kbc", AWEA_IDX_STS3, 8'h0c);
    rd_chk("global", AWEA_IDX_GSTS, 8'h00);
    // Clear while the source still drives the bit
    pin_b1 <= 4'h1;
    settle();
    wr(AWEA_IDX_STS1, 8'h0f);
    rd_chk("set wins", AWEA_IDX_STS1, 8'h01);
    // Global status and SCI gating
    wr(AWEA_IDX_EN1, 8'h0f);
    ev("bank1", AWEA_IDX_STS1, 8'h01);
    pin_b1 <= 4'h2;
    settle();
    idle();
    settle();
    rd_chk("global", AWEA_IDX_GSTS, 8'h01);
    chk1("sci", 1'b0, sci);
    wr(AWEA_IDX_GSTS, 8'h01);
    rd_chk("global", AWEA_IDX_GSTS, 8'h01);
    wr(AWEA_IDX_GEN, 8'h01);
    settle();
    chk1("sci", 1'b1, sci);
    chk32("sci rises", 32'h0000_0001, {24'h00_0000, sci_rises});
    chk1("irq masked", 1'b0, irq);
    wr(AWEA_IDX_STS1, 8'h0f);
    wr(AWEA_IDX_GSTS, 8'h01);
    rd_chk("global", AWEA_IDX_GSTS, 8'h00);
    settle();
    chk1("sci", 1'b0, sci);
    // Block interrupt: mask, raise, clear on read
    wr(AWEA_IDX_IRQ_MSK, 8'h01);
    settle();
    chk1("irq", 1'b1, irq);
    rd_chk("irq status", AWEA_IDX_IRQ_STS, 8'h03);
    settle();
    chk1("irq", 1'b0, irq);
    rd_chk("irq status", AWEA_IDX_IRQ_STS, 8'h00);
    // Reset in mid-run wipes the enables written above
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("reset", AWEA_IDX_EN1, 8'h00);
    rd_chk("reset", AWEA_IDX_GEN, 8'h00);
    give_verdict();
  end
endmodule : testbench
